// ==== core/dctg_pkg.sv ====
`default_nettype none
package dctg_pkg;

	// Clock and power-up timing.
	localparam int CLK_PERIOD_NS   = 10;
	localparam int POWERUP_WAIT_US = 500;
	localparam int POWERUP_CYCLES  = (POWERUP_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Geometry and widths.
	localparam int NUM_BANKS = 8;
	localparam int BANK_W    = 3;
	localparam int CFG_W     = 8;
	localparam int CNT_W     = 9;
	localparam int ADDR_W    = 8;

	// Register byte offsets.
	localparam logic [ADDR_W-1:0] REG_ROW_OPEN   = 8'h00;
	localparam logic [ADDR_W-1:0] REG_ROW_TO_COL = 8'h04;
	localparam logic [ADDR_W-1:0] REG_ROW_CLOSE  = 8'h08;
	localparam logic [ADDR_W-1:0] REG_WRITE_REC  = 8'h0c;
	localparam logic [ADDR_W-1:0] REG_MODE_SET   = 8'h10;
	localparam logic [ADDR_W-1:0] REG_BURST      = 8'h14;
	localparam logic [ADDR_W-1:0] REG_STATUS     = 8'h18;

	// Reset values: times in ns, mode spacing and burst in cycles.
	localparam logic [CFG_W-1:0] RST_ROW_OPEN   = 8'h23;
	localparam logic [CFG_W-1:0] RST_ROW_TO_COL = 8'h0e;
	localparam logic [CFG_W-1:0] RST_ROW_CLOSE  = 8'h0e;
	localparam logic [CFG_W-1:0] RST_WRITE_REC  = 8'h0f;
	localparam logic [CFG_W-1:0] RST_MODE_SET   = 8'h04;
	localparam logic [CFG_W-1:0] RST_BURST      = 8'h04;

	// Status field positions.
	localparam int STAT_CKE_BIT  = 0;
	localparam int STAT_INIT_BIT = 1;
	localparam int STAT_BUSY_LSB = 8;

	// Bus response codes.
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [2:0] {
		DCTG_NOP,
		DCTG_MRS,
		DCTG_ACT,
		DCTG_PRE,
		DCTG_RD,
		DCTG_WR
	} dctg_op_t;

	typedef struct packed {
		dctg_op_t            op;
		logic [BANK_W-1:0]   bank;
	} dctg_cmd_t;

endpackage
`default_nettype wire

// ==== core/dctg_guard.sv ====
`timescale 1ns/1ps
`default_nettype none

module dctg_guard #(
	parameter int POWERUP_CYC = dctg_pkg::POWERUP_CYCLES
) (
	input  wire logic                           aclk,
	input  wire logic                           aresetn,
	input  wire logic                           ce,
	input  wire logic                           cmd_valid,
	input  wire dctg_pkg::dctg_cmd_t            cmd_req,
	output logic                                cmd_ready,
	output dctg_pkg::dctg_cmd_t                 mem_cmd,
	output logic                                mem_cmd_valid,
	output logic                                mem_cke,
	input  wire logic [dctg_pkg::ADDR_W-1:0]    awaddr,
	input  wire logic                           awvalid,
	output logic                                awready,
	input  wire logic [31:0]                    wdata,
	input  wire logic [3:0]                     wstrb,
	input  wire logic                           wvalid,
	output logic                                wready,
	output logic [1:0]                          bresp,
	output logic                                bvalid,
	input  wire logic                           bready,
	input  wire logic [dctg_pkg::ADDR_W-1:0]    araddr,
	input  wire logic                           arvalid,
	output logic                                arready,
	output logic [31:0]                         rdata,
	output logic [1:0]                          rresp,
	output logic                                rvalid,
	input  wire logic                           rready
);

	localparam int INIT_W = $clog2(POWERUP_CYC + 1);
	localparam int CW     = dctg_pkg::CNT_W;
	localparam int NB     = dctg_pkg::NUM_BANKS;

	// Nanoseconds to whole cycles, rounded up so a minimum is never shortened.
	function automatic logic [CW-1:0] ns_to_cyc(input logic [dctg_pkg::CFG_W-1:0] ns);
		logic [CW+3:0] sum;
		sum = (CW+4)'(ns) + (CW+4)'(dctg_pkg::CLK_PERIOD_NS - 1);
		return CW'(sum / (CW+4)'(dctg_pkg::CLK_PERIOD_NS));
	endfunction

	// A spacing of N cycles loads N-1, because the issuing edge itself is the first cycle.
	function automatic logic [CW-1:0] dly_load(input logic [CW-1:0] cyc);
		return (cyc == '0) ? '0 : CW'(cyc - CW'(1));
	endfunction

	// Loop index to bank number, cut to the bank field on purpose.
	function automatic logic [dctg_pkg::BANK_W-1:0] bank_idx(input int b);
		return dctg_pkg::BANK_W'(b);
	endfunction

	logic [dctg_pkg::CFG_W-1:0] row_open_min_time;
	logic [dctg_pkg::CFG_W-1:0] row_to_column_delay;
	logic [dctg_pkg::CFG_W-1:0] row_close_period;
	logic [dctg_pkg::CFG_W-1:0] write_recovery_time;
	logic [dctg_pkg::CFG_W-1:0] mode_set_spacing_cycles;
	logic [dctg_pkg::CFG_W-1:0] burst_cycles;
	logic [INIT_W-1:0]          init_cnt;
	logic [CW-1:0]              mrd_cnt;
	logic [CW-1:0]              ras_cnt [NB];
	logic [CW-1:0]              rcd_cnt [NB];
	logic [CW-1:0]              rp_cnt  [NB];
	logic [CW-1:0]              wr_cnt  [NB];
	logic [NB-1:0]              bank_busy;
	logic [NB-1:0]              bank_hit;

	// Converted loads, shared by every bank.
	wire logic [CW-1:0] ras_load = dly_load(ns_to_cyc(row_open_min_time));
	wire logic [CW-1:0] rcd_load = dly_load(ns_to_cyc(row_to_column_delay));
	wire logic [CW-1:0] rp_load  = dly_load(ns_to_cyc(row_close_period));
	wire logic [CW-1:0] wr_load  = dly_load(CW'(ns_to_cyc(write_recovery_time) + CW'(burst_cycles)));
	wire logic [CW-1:0] mrd_load = dly_load(CW'(mode_set_spacing_cycles));

	// Eligibility of the offered command against the counters of its bank, or the global mode-set counter for a mode set.
	wire logic ras_zero = (ras_cnt[cmd_req.bank] == '0);
	wire logic rcd_zero = (rcd_cnt[cmd_req.bank] == '0);
	wire logic rp_zero  = (rp_cnt[cmd_req.bank] == '0);
	wire logic wr_zero  = (wr_cnt[cmd_req.bank] == '0);
	wire logic mrd_zero = (mrd_cnt == '0);
	wire logic is_mrs   = (cmd_req.op == dctg_pkg::DCTG_MRS);
	wire logic is_act   = (cmd_req.op == dctg_pkg::DCTG_ACT);
	wire logic is_pre   = (cmd_req.op == dctg_pkg::DCTG_PRE);
	wire logic is_col   = (cmd_req.op == dctg_pkg::DCTG_RD) || (cmd_req.op == dctg_pkg::DCTG_WR);
	wire logic is_wr    = (cmd_req.op == dctg_pkg::DCTG_WR);
	wire logic timing_ok = (!is_mrs || mrd_zero)
		&& (!is_pre || (ras_zero && wr_zero))
		&& (!is_col || rcd_zero)
		&& (!is_act || rp_zero);
	assign cmd_ready = mem_cke && timing_ok;
	wire logic issue = ce && cmd_valid && cmd_ready;

	// Power-up wait; counted on aclk only in cycles with ce high, since the memory needs no clock to initialise.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			init_cnt <= INIT_W'(POWERUP_CYC);
		else if (ce && init_cnt != '0)
			init_cnt <= init_cnt - INIT_W'(1);
	end

	// Clock enable only rises once the full wait has run out.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			mem_cke <= 1'b0;
		else if (ce)
			mem_cke <= (init_cnt == '0);
	end

	// Issued command register toward the memory pins.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mem_cmd       <= '{op: dctg_pkg::DCTG_NOP, bank: '0};
			mem_cmd_valid <= 1'b0;
		end
		else if (ce)
		begin
			mem_cmd_valid <= issue;
			mem_cmd       <= issue ? cmd_req : '{op: dctg_pkg::DCTG_NOP, bank: '0};
		end
	end

	// Global mode-set spacing counter.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			mrd_cnt <= '0;
		else if (ce)
			mrd_cnt <= (issue && is_mrs) ? mrd_load : (mrd_zero ? '0 : mrd_cnt - CW'(1));
	end

	// Per-bank down-counters; an issue reloads only the counters its command starts.
	always_ff @(posedge aclk)
	begin
		for (int b = 0; b < NB; b++)
		begin
			if (!aresetn)
			begin
				ras_cnt[b] <= '0;
				rcd_cnt[b] <= '0;
				rp_cnt[b]  <= '0;
				wr_cnt[b]  <= '0;
			end
			else if (ce)
			begin
				ras_cnt[b] <= (bank_hit[b] && is_act) ? ras_load : (ras_cnt[b] == '0 ? '0 : ras_cnt[b] - CW'(1));
				rcd_cnt[b] <= (bank_hit[b] && is_act) ? rcd_load : (rcd_cnt[b] == '0 ? '0 : rcd_cnt[b] - CW'(1));
				rp_cnt[b]  <= (bank_hit[b] && is_pre) ? rp_load  : (rp_cnt[b] == '0 ? '0 : rp_cnt[b] - CW'(1));
				wr_cnt[b]  <= (bank_hit[b] && is_wr)  ? wr_load  : (wr_cnt[b] == '0 ? '0 : wr_cnt[b] - CW'(1));
			end
		end
	end

	// Busy mask for status, and which bank the command issued this cycle addresses.
	always_comb
	begin
		for (int b = 0; b < NB; b++)
		begin
			bank_busy[b] = (ras_cnt[b] != '0) || (rcd_cnt[b] != '0) || (rp_cnt[b] != '0) || (wr_cnt[b] != '0);
			bank_hit[b]  = issue && (cmd_req.bank == bank_idx(b));
		end
	end

	// Write path takes address and data in the same cycle, so neither can be left behind.
	wire logic wr_go  = ce && awvalid && wvalid && !bvalid;
	wire logic wr_hit = (awaddr == dctg_pkg::REG_ROW_OPEN) || (awaddr == dctg_pkg::REG_ROW_TO_COL)
		|| (awaddr == dctg_pkg::REG_ROW_CLOSE) || (awaddr == dctg_pkg::REG_WRITE_REC)
		|| (awaddr == dctg_pkg::REG_MODE_SET) || (awaddr == dctg_pkg::REG_BURST)
		|| (awaddr == dctg_pkg::REG_STATUS);
	assign awready = wr_go;
	assign wready  = wr_go;
	wire logic [7:0] wbyte = wdata[7:0];
	wire logic       wlane = wr_go && wstrb[0];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			row_open_min_time       <= dctg_pkg::RST_ROW_OPEN;
			row_to_column_delay     <= dctg_pkg::RST_ROW_TO_COL;
			row_close_period        <= dctg_pkg::RST_ROW_CLOSE;
			write_recovery_time     <= dctg_pkg::RST_WRITE_REC;
			mode_set_spacing_cycles <= dctg_pkg::RST_MODE_SET;
			burst_cycles            <= dctg_pkg::RST_BURST;
		end
		else if (wlane)
		begin
			if (awaddr == dctg_pkg::REG_ROW_OPEN)
				row_open_min_time <= wbyte;
			else if (awaddr == dctg_pkg::REG_ROW_TO_COL)
				row_to_column_delay <= wbyte;
			else if (awaddr == dctg_pkg::REG_ROW_CLOSE)
				row_close_period <= wbyte;
			else if (awaddr == dctg_pkg::REG_WRITE_REC)
				write_recovery_time <= wbyte;
			else if (awaddr == dctg_pkg::REG_MODE_SET)
				mode_set_spacing_cycles <= wbyte;
			else if (awaddr == dctg_pkg::REG_BURST)
				burst_cycles <= wbyte;
		end
	end

	// Write response; status is read-only and takes writes silently.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid <= 1'b0;
			bresp  <= dctg_pkg::RESP_OKAY;
		end
		else if (ce)
		begin
			if (wr_go)
			begin
				bvalid <= 1'b1;
				bresp  <= wr_hit ? dctg_pkg::RESP_OKAY : dctg_pkg::RESP_SLVERR;
			end
			else if (bready)
				bvalid <= 1'b0;
		end
	end

	// Read decode.
	wire logic rd_go = ce && arvalid && !rvalid;
	wire logic [31:0] stat_word = (32'(bank_busy) << dctg_pkg::STAT_BUSY_LSB)
		| (32'(mem_cke) << dctg_pkg::STAT_INIT_BIT) | (32'(mem_cke) << dctg_pkg::STAT_CKE_BIT);
	wire logic rd_hit = (araddr == dctg_pkg::REG_ROW_OPEN) || (araddr == dctg_pkg::REG_ROW_TO_COL)
		|| (araddr == dctg_pkg::REG_ROW_CLOSE) || (araddr == dctg_pkg::REG_WRITE_REC)
		|| (araddr == dctg_pkg::REG_MODE_SET) || (araddr == dctg_pkg::REG_BURST)
		|| (araddr == dctg_pkg::REG_STATUS);
	wire logic [31:0] rd_word =
		(araddr == dctg_pkg::REG_ROW_OPEN)   ? 32'(row_open_min_time) :
		(araddr == dctg_pkg::REG_ROW_TO_COL) ? 32'(row_to_column_delay) :
		(araddr == dctg_pkg::REG_ROW_CLOSE)  ? 32'(row_close_period) :
		(araddr == dctg_pkg::REG_WRITE_REC)  ? 32'(write_recovery_time) :
		(araddr == dctg_pkg::REG_MODE_SET)   ? 32'(mode_set_spacing_cycles) :
		(araddr == dctg_pkg::REG_BURST)      ? 32'(burst_cycles) :
		(araddr == dctg_pkg::REG_STATUS)     ? stat_word : 32'h0000_0000;
	assign arready = rd_go;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= dctg_pkg::RESP_OKAY;
		end
		else if (ce)
		begin
			if (rd_go)
			begin
				rvalid <= 1'b1;
				rdata  <= rd_word;
				rresp  <= rd_hit ? dctg_pkg::RESP_OKAY : dctg_pkg::RESP_SLVERR;
			end
			else if (rready)
				rvalid <= 1'b0;
		end
	end

	// Checks on the power-up wait and on the issued command stream.
	default clocking dctg_cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence act_taken;
		issue && is_act;
	endsequence

	sequence wr_taken;
		issue && is_wr;
	endsequence

	cke_held_low_a: assert property ((init_cnt != '0) |=> !mem_cke)
		else $error("clock enable rose before the power-up wait ended");
	init_count_steps_a: assert property ((ce && init_cnt != '0) |=> init_cnt == $past(init_cnt) - INIT_W'(1))
		else $error("power-up counter did not step on its own clock");
	mode_set_gap_a: assert property ((issue && is_mrs) |-> mrd_cnt == '0)
		else $error("mode register set issued too soon");
	row_open_min_a: assert property ((issue && is_pre) |-> ras_cnt[cmd_req.bank] == '0)
		else $error("precharge issued before row open minimum");
	col_after_act_a: assert property ((issue && is_col) |-> rcd_cnt[cmd_req.bank] == '0)
		else $error("column command issued before row-to-column delay");
	act_after_pre_a: assert property ((issue && is_act) |-> rp_cnt[cmd_req.bank] == '0)
		else $error("activate issued before row close period");
	wr_recovery_a: assert property (wr_taken ##1 ce |-> wr_cnt[$past(cmd_req.bank)] == $past(wr_load))
		else $error("write recovery counter not loaded");
	act_loads_rcd_a: assert property (act_taken |=> rcd_cnt[$past(cmd_req.bank)] == $past(rcd_load))
		else $error("row-to-column counter not loaded on activate");
	issued_matches_a: assert property ((ce && issue) |=> mem_cmd_valid && mem_cmd == $past(cmd_req))
		else $error("issued command not presented to memory");

endmodule
`default_nettype wire

// ==== verification/dctg_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Memory side of the command port: counts every command that arrives too soon.
module dctg_mem_model (
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic                mem_cke,
	input  wire logic                mem_cmd_valid,
	input  wire dctg_pkg::dctg_cmd_t mem_cmd,
	input  wire logic [7:0]          sp_mrs,
	input  wire logic [7:0]          sp_ras,
	input  wire logic [7:0]          sp_rcd,
	input  wire logic [7:0]          sp_rp,
	input  wire logic [7:0]          sp_wr,
	output int                       viol
);
	int               now;
	int               t_mrs;
	int               t_act [8];
	int               t_pre [8];
	int               t_wr [8];
	int               b;
	dctg_pkg::dctg_op_t op;

	// Histories start far back so that the first command of a bank is always legal.
	always @(posedge aclk)
	begin
		now = now + 1;
		op = mem_cmd.op;
		b = int'(mem_cmd.bank);
		if (!aresetn)
		begin
			viol = 0;
			t_mrs = -999;
			t_act = '{default: -999};
			t_pre = '{default: -999};
			t_wr = '{default: -999};
		end
		else if (mem_cmd_valid === 1'b1)
		begin
			viol += int'(!mem_cke);
			viol += int'(op == dctg_pkg::DCTG_MRS && now - t_mrs < sp_mrs);
			viol += int'(op == dctg_pkg::DCTG_PRE && now - t_act[b] < sp_ras);
			viol += int'((op == dctg_pkg::DCTG_RD || op == dctg_pkg::DCTG_WR) && now - t_act[b] < sp_rcd);
			viol += int'(op == dctg_pkg::DCTG_ACT && now - t_pre[b] < sp_rp);
			viol += int'(op == dctg_pkg::DCTG_PRE && now - t_wr[b] < sp_wr);
			case (op)
				dctg_pkg::DCTG_MRS: t_mrs = now;
				dctg_pkg::DCTG_ACT: t_act[b] = now;
				dctg_pkg::DCTG_PRE: t_pre[b] = now;
				dctg_pkg::DCTG_WR:  t_wr[b] = now;
				default: ;
			endcase
		end
	end
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int PWR = 20;
	logic                aclk, aresetn, cmd_valid, cmd_ready, mem_cmd_valid, mem_cke;
	dctg_pkg::dctg_cmd_t cmd_req, mem_cmd;
	logic [7:0]          awaddr, araddr, sp_mrs, sp_ras, sp_rcd, sp_rp, sp_wr;
	logic                awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0]         wdata, rdata, d;
	logic [1:0]          bresp, rresp, r;
	int                  cyc, num_errors, compares, viol;
	int                  q_t [$];
	dctg_pkg::dctg_cmd_t q_c [$];

	dctg_guard #(.POWERUP_CYC(PWR)) u_dctg_guard (.aclk, .aresetn, .ce(1'b1), .cmd_valid, .cmd_req, .cmd_ready,
		.mem_cmd, .mem_cmd_valid, .mem_cke, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
	dctg_mem_model u_dctg_mem_model (.aclk, .aresetn, .mem_cke, .mem_cmd_valid, .mem_cmd, .sp_mrs, .sp_ras,
		.sp_rcd, .sp_rp, .sp_wr, .viol);

	// Free-running 100 MHz clock and a cycle count for spacing measurements.
	initial
	begin
		aclk = 0;
		forever #5 aclk = ~aclk;
	end
	always @(posedge aclk) cyc <= cyc + 1;

	function automatic logic [7:0] cyc_of(input int ns);
		return 8'((ns + dctg_pkg::CLK_PERIOD_NS - 1) / dctg_pkg::CLK_PERIOD_NS);
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		compares++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("ERROR %0t: %s seen %0h expected %0h", $time, what, seen, exp);
		end
	endtask

	task automatic print_verdict;
		$display("compares %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Run is a few hundred cycles; ten thousand means the bench is hung.
	initial
	begin
		#100000;
		num_errors++;
		print_verdict();
	end

	// Every issued command must come out exactly one cycle after it was taken.
	always @(negedge aclk)
		if (mem_cmd_valid === 1'b1)
		begin
			check(mem_cmd, q_c.pop_front(), "issued command");
			// Taken at edge t, so it is seen here with cyc equal to t and stands until edge t+1.
			check(cyc, q_t.pop_front(), "issue latency");
		end

	// Holds the command until taken; leaves valid up so a follow-on can be offered at once.
	task automatic issue(input dctg_pkg::dctg_op_t op, input logic [2:0] bank, output int t);
		logic rdy;
		cmd_valid <= 1'b1;
		cmd_req <= '{op, bank};
		rdy = 0;
		while (!rdy)
		begin
			@(negedge aclk);
			rdy = cmd_ready;
			@(posedge aclk);
		end
		t = cyc + 1;
		q_c.push_back('{op, bank});
		q_t.push_back(t);
	endtask

	task automatic pair(input dctg_pkg::dctg_op_t o1, input logic [2:0] b1, input dctg_pkg::dctg_op_t o2,
		input logic [2:0] b2, input int exp);
		int t1, t2;
		issue(o1, b1, t1);
		issue(o2, b2, t2);
		cmd_valid <= 1'b0;
		repeat (12) @(posedge aclk);
		check(t2 - t1, exp, "spacing");
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		logic sa, sw, sb;
		@(posedge aclk);
		{awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'b111};
		sb = 0;
		while (!sb)
		begin
			@(negedge aclk);
			{sa, sw, sb, rs} = {awready & awvalid, wready & wvalid, bvalid, bresp};
			@(posedge aclk);
			if (sa) awvalid <= 1'b0;
			if (sw) wvalid <= 1'b0;
			if (sb) bready <= 1'b0;
		end
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		logic sa, sb;
		@(posedge aclk);
		{araddr, arvalid, rready} <= {a, 2'b11};
		sb = 0;
		while (!sb)
		begin
			@(negedge aclk);
			{sa, sb, v, rs} = {arready & arvalid, rvalid, rdata, rresp};
			@(posedge aclk);
			if (sa) arvalid <= 1'b0;
			if (sb) rready <= 1'b0;
		end
	endtask

	task automatic t_powerup;
		int n;
		n = 0;
		@(negedge aclk);
		check(cmd_ready, 0, "ready before cke");
		while (mem_cke !== 1'b1 && n < 100)
		begin
			@(posedge aclk);
			n++;
			@(negedge aclk);
		end
		check(n, PWR + 1, "cke delay");
		$display("powerup done");
	endtask

	task automatic t_regs;
		logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
		logic [7:0] rv [6] = '{8'h23, 8'h0e, 8'h0e, 8'h0f, 8'h04, 8'h04};
		foreach (ra[i])
		begin
			axi_rd(ra[i], d, r);
			check(r, dctg_pkg::RESP_OKAY, "reset read response");
			check(d, {24'h0, rv[i]}, "reset value");
		end
		axi_wr(dctg_pkg::REG_STATUS, 32'h0, r);
		check(r, dctg_pkg::RESP_OKAY, "status write response");
		axi_rd(dctg_pkg::REG_STATUS, d, r);
		check(d, 32'h3, "status");
		axi_wr(8'h1c, 32'h55, r);
		check(r, dctg_pkg::RESP_SLVERR, "unmapped write");
		axi_rd(8'h1c, d, r);
		check(r, dctg_pkg::RESP_SLVERR, "unmapped read response");
		check(d, 32'h0, "unmapped read data");
		$display("registers done");
	endtask

	task automatic t_default;
		pair(dctg_pkg::DCTG_ACT, 0, dctg_pkg::DCTG_RD, 0, sp_rcd);
		pair(dctg_pkg::DCTG_ACT, 1, dctg_pkg::DCTG_PRE, 1, sp_ras);
		pair(dctg_pkg::DCTG_PRE, 1, dctg_pkg::DCTG_ACT, 1, sp_rp);
		pair(dctg_pkg::DCTG_MRS, 0, dctg_pkg::DCTG_MRS, 0, sp_mrs);
		pair(dctg_pkg::DCTG_ACT, 2, dctg_pkg::DCTG_ACT, 3, 1);
		pair(dctg_pkg::DCTG_WR, 2, dctg_pkg::DCTG_PRE, 2, sp_wr);
		$display("default spacing done");
	endtask

	// Odd nanosecond values check that times round up, not down.
	task automatic t_config;
		axi_wr(dctg_pkg::REG_ROW_OPEN, 32'd81, r);
		check(r, dctg_pkg::RESP_OKAY, "config write response");
		axi_wr(dctg_pkg::REG_MODE_SET, 32'd7, r);
		check(r, dctg_pkg::RESP_OKAY, "config write response");
		axi_wr(dctg_pkg::REG_WRITE_REC, 32'd21, r);
		check(r, dctg_pkg::RESP_OKAY, "config write response");
		axi_rd(dctg_pkg::REG_ROW_OPEN, d, r);
		check(d, 32'd81, "readback");
		sp_ras = cyc_of(81);
		sp_mrs = 8'd7;
		sp_wr = cyc_of(21) + dctg_pkg::RST_BURST;
		pair(dctg_pkg::DCTG_ACT, 4, dctg_pkg::DCTG_PRE, 4, 9);
		pair(dctg_pkg::DCTG_MRS, 0, dctg_pkg::DCTG_MRS, 0, 7);
		pair(dctg_pkg::DCTG_ACT, 5, dctg_pkg::DCTG_WR, 5, sp_rcd);
		pair(dctg_pkg::DCTG_WR, 5, dctg_pkg::DCTG_PRE, 5, 7);
		$display("configured spacing done");
	endtask

	initial
	begin
		{aresetn, cmd_valid, awvalid, wvalid, bready, arvalid, rready, num_errors, compares} = '0;
		{awaddr, araddr, wdata} = '0;
		cmd_req = '{dctg_pkg::DCTG_NOP, 3'h0};
		sp_mrs = dctg_pkg::RST_MODE_SET;
		sp_ras = cyc_of(dctg_pkg::RST_ROW_OPEN);
		sp_rcd = cyc_of(dctg_pkg::RST_ROW_TO_COL);
		sp_rp = cyc_of(dctg_pkg::RST_ROW_CLOSE);
		sp_wr = cyc_of(dctg_pkg::RST_WRITE_REC) + dctg_pkg::RST_BURST;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		t_powerup();
		t_regs();
		t_default();
		t_config();
		check(viol, 0, "memory spacing");
		check(q_c.size(), 0, "missing command");
		print_verdict();
	end
endmodule
`default_nettype wire
